// ==== verilog/xfs_cfg.svh ====
`ifndef XFS_CFG_SVH
`define XFS_CFG_SVH

// register byte offsets on the register bus
`define XFS_OFS_FLOW_STATUS   8'h00
`define XFS_OFS_RECOG_CTRL    8'h04
`define XFS_OFS_MODE_CTRL     8'h08
`define XFS_OFS_INT_STATUS    8'h0C

// flow_control_status field positions
`define XFS_RX_FIELD_HI       7
`define XFS_RX_FIELD_LO       6
`define XFS_SENT_FIELD_HI     5
`define XFS_SENT_FIELD_LO     4
`define XFS_TXFLOW_HI         3
`define XFS_TXFLOW_LO         2
`define XFS_TXCHAR_HI         1
`define XFS_TXCHAR_LO         0

// two-bit codes shared by the flow fields
`define XFS_CODE_NONE         2'h0
`define XFS_CODE_01           2'h1
`define XFS_CODE_10           2'h2
`define XFS_CODE_11           2'h3

// recognition_enable_ctrl bit pairs (enable, disable)
`define XFS_RE_WDOG_DIS       7
`define XFS_RE_WDOG_EN        6
`define XFS_RE_ADDR_DIS       5
`define XFS_RE_ADDR_EN        4
`define XFS_RE_XON_DIS        3
`define XFS_RE_XON_EN         2
`define XFS_RE_XOFF_DIS       1
`define XFS_RE_XOFF_EN        0

// mode control bits
`define XFS_MC_AUTO_RX        0
`define XFS_MC_AUTO_TX        1

// interrupt_status bits
`define XFS_IS_XON            0
`define XFS_IS_XOFF           1
`define XFS_IS_ADDR           2
`define XFS_IS_GEN            3

// bit times in one character, and timer width
`define XFS_CHAR_BITS         4'hA
`define XFS_BITCNT_ONE        4'h1
`define XFS_BITCNT_ZERO       4'h0

// bus answers and reset values
`define XFS_RESP_OKAY         2'h0
`define XFS_RESP_SLVERR       2'h2
`define XFS_WORD_ZERO         32'h0000_0000
`define XFS_BYTE_ZERO         8'h00
`define XFS_NIB_ZERO          4'h0

`endif

// ==== verilog/xfs_pkg.sv ====
package xfs_pkg;

	// transmitter flow state, declared in the order of its printed codes
	typedef enum logic [1:0] {
		XFS_TF_NORMAL,
		XFS_TF_HALT_PEND,
		XFS_TF_REENABLED,
		XFS_TF_HALTED
	} xfs_txflow_e;

	// transmit character status
	typedef enum logic [1:0] {
		XFS_TC_NORMAL,
		XFS_TC_IDLE_WAIT,
		XFS_TC_STOP_PEND,
		XFS_TC_RESUME_PEND
	} xfs_txchar_e;

	typedef logic [1:0] xfs_code_t;

endpackage

// ==== verilog/xfs_flow_if.sv ====
`timescale 1ns/1ps
interface xfs_flow_if;
	logic                   halt_req;      // stop character acted upon
	logic                   resume_req;    // resume character acted upon
	logic                   tx_busy;       // character in progress
	logic                   tx_char_done;  // character just finished
	logic                   bit_tick;      // one pulse per bit time
	logic                   queue_empty;   // tx_queue has no data
	logic                   send_stop;     // command to send stop char
	logic                   send_resume;   // command to send resume char
	logic                   sent_stop;     // stop char left the line
	logic                   sent_resume;   // resume char left the line
	logic                   status_read;   // flow_control_status read
	xfs_pkg::xfs_code_t     flow_code;     // transmitter flow field
	xfs_pkg::xfs_code_t     char_code;     // transmit char field
	logic                   tx_halt;       // transmitter held off

	modport core (output halt_req, resume_req, tx_busy, tx_char_done, bit_tick,
		queue_empty, send_stop, send_resume, sent_stop, sent_resume, status_read,
		input flow_code, char_code, tx_halt);
	modport flow (input halt_req, resume_req, tx_busy, tx_char_done, bit_tick,
		queue_empty, send_stop, send_resume, sent_stop, sent_resume, status_read,
		output flow_code, char_code, tx_halt);
endinterface

// ==== verilog/xfs_tx_flow.sv ====
`timescale 1ns/1ps
`include "xfs_cfg.svh"
module xfs_tx_flow (
	input  wire logic       clock,   // system clock
	input  wire logic       rst_b,   // async reset, active low
	xfs_flow_if.flow        fl       // flow events and status
);
	xfs_pkg::xfs_txflow_e   flow_st, next_flow_st;
	xfs_pkg::xfs_txchar_e   char_st, next_char_st;
	logic [3:0]             bit_cnt, next_bit_cnt;

	// transmitter halt and resume tracking
	always_comb begin
		next_flow_st = flow_st;
		unique case (flow_st)
			xfs_pkg::XFS_TF_NORMAL, xfs_pkg::XFS_TF_REENABLED: begin
				if (fl.halt_req)
					next_flow_st = fl.tx_busy ? xfs_pkg::XFS_TF_HALT_PEND
						: xfs_pkg::XFS_TF_HALTED;
				else if (flow_st == xfs_pkg::XFS_TF_REENABLED && fl.status_read)
					next_flow_st = xfs_pkg::XFS_TF_NORMAL;
			end
			xfs_pkg::XFS_TF_HALT_PEND: begin
				if (fl.resume_req)
					next_flow_st = xfs_pkg::XFS_TF_NORMAL;
				else if (fl.tx_char_done)
					next_flow_st = xfs_pkg::XFS_TF_HALTED;
			end
			xfs_pkg::XFS_TF_HALTED: begin
				if (fl.resume_req)
					next_flow_st = xfs_pkg::XFS_TF_REENABLED;
			end
		endcase
	end

	// pending flow characters; the bit counter bounds each pending code
	always_comb begin
		next_char_st = char_st;
		next_bit_cnt = fl.bit_tick ? bit_cnt + `XFS_BITCNT_ONE : bit_cnt;
		unique case (char_st)
			xfs_pkg::XFS_TC_NORMAL, xfs_pkg::XFS_TC_IDLE_WAIT: begin
				if (fl.send_stop) begin
					next_char_st = xfs_pkg::XFS_TC_STOP_PEND;
					next_bit_cnt = `XFS_BITCNT_ZERO;
				end else if (fl.send_resume) begin
					next_char_st = xfs_pkg::XFS_TC_RESUME_PEND;
					next_bit_cnt = `XFS_BITCNT_ZERO;
				end else if (char_st == xfs_pkg::XFS_TC_IDLE_WAIT && fl.bit_tick
					&& !fl.queue_empty)
					next_char_st = xfs_pkg::XFS_TC_NORMAL;
			end
			xfs_pkg::XFS_TC_STOP_PEND, xfs_pkg::XFS_TC_RESUME_PEND: begin
				// a pending code never outlives one character time
				if (fl.sent_stop || fl.sent_resume ||
					(fl.bit_tick && bit_cnt + `XFS_BITCNT_ONE >= `XFS_CHAR_BITS)) begin
					next_char_st = xfs_pkg::XFS_TC_IDLE_WAIT;
					next_bit_cnt = `XFS_BITCNT_ZERO;
				end
			end
		endcase
	end

	// state registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flow_st <= xfs_pkg::XFS_TF_NORMAL;
			char_st <= xfs_pkg::XFS_TC_NORMAL;
			bit_cnt <= `XFS_BITCNT_ZERO;
		end else begin
			flow_st <= next_flow_st;
			char_st <= next_char_st;
			bit_cnt <= next_bit_cnt;
		end
	end

	// enum order matches printed codes
	assign fl.flow_code = xfs_pkg::xfs_code_t'(flow_st);
	assign fl.char_code = xfs_pkg::xfs_code_t'(char_st);
	assign fl.tx_halt   = (flow_st == xfs_pkg::XFS_TF_HALTED);
endmodule // xfs_tx_flow

// ==== verilog/xfs_recog.sv ====
`timescale 1ns/1ps
`include "xfs_cfg.svh"
module xfs_recog (
	input  wire logic       clock,     // system clock
	input  wire logic       rst_b,     // async reset, active low
	input  wire logic       wr_stb,    // one-cycle write strobe
	input  wire logic [7:0] wr_data,   // written enable/disable bits
	output logic            wdog_en,   // receiver watchdog enabled
	output logic            addr_en,   // address recognition enabled
	output logic            xon_en,    // resume char recognition
	output logic            xoff_en    // stop char recognition
);
	logic next_wdog, next_addr, next_xon, next_xoff;

	// disable beats enable; neither bit set keeps the state
	function automatic logic merge(input logic cur, input logic en, input logic dis);
		merge = dis ? 1'b0 : (en ? 1'b1 : cur);
	endfunction

	// one enable per function, updated only by a write
	always_comb begin
		next_wdog = wdog_en;
		next_addr = addr_en;
		next_xon  = xon_en;
		next_xoff = xoff_en;
		if (wr_stb) begin
			next_wdog = merge(wdog_en, wr_data[`XFS_RE_WDOG_EN], wr_data[`XFS_RE_WDOG_DIS]);
			next_addr = merge(addr_en, wr_data[`XFS_RE_ADDR_EN], wr_data[`XFS_RE_ADDR_DIS]);
			next_xon  = merge(xon_en, wr_data[`XFS_RE_XON_EN], wr_data[`XFS_RE_XON_DIS]);
			next_xoff = merge(xoff_en, wr_data[`XFS_RE_XOFF_EN], wr_data[`XFS_RE_XOFF_DIS]);
		end
	end

	// enable registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wdog_en <= 1'b0;
			addr_en <= 1'b0;
			xon_en  <= 1'b0;
			xoff_en <= 1'b0;
		end else begin
			wdog_en <= next_wdog;
			addr_en <= next_addr;
			xon_en  <= next_xon;
			xoff_en <= next_xoff;
		end
	end
endmodule // xfs_recog

// ==== verilog/xfs_top.sv ====
`timescale 1ns/1ps
`include "xfs_cfg.svh"
// Contract
// - sent field: none, resume, stop, both
// - sent field reads 00 unless auto mode
// - clearing auto mode clears sent field
// - code 00: transmitter runs normally
// - halt pending finishes character, then 11
// - code 10 after halted transmitter restarts
// - status read returns 10 to normal
// - code 11 while stopped by stop character
// - char status 00 normal, 01 idle wait
// - idle wait ends on a bit time with tx_queue not empty
// - 10 stop pending, 11 resume pending
// - pending codes last at most one character
// - enable register drives recognition and watchdog
// - enable and disable together means disable
// - general recognition without flow actions
// - recognition events flagged in interrupt status
// - status read clears upper four bits
// - received field updates regardless of enables
// - writing zero to a recognition or interrupt bit does nothing
module xfs_top (
	input  wire logic        clock,           // 125 MHz system clock
	input  wire logic        rst_b,           // async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,    // write address
	input  wire logic        s_axi_awvalid,   // write address valid
	output logic             s_axi_awready,   // write address ready
	input  wire logic [31:0] s_axi_wdata,     // write data
	input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
	input  wire logic        s_axi_wvalid,    // write data valid
	output logic             s_axi_wready,    // write data ready
	output logic [1:0]       s_axi_bresp,     // write response
	output logic             s_axi_bvalid,    // write response valid
	input  wire logic        s_axi_bready,    // write response ready
	input  wire logic [7:0]  s_axi_araddr,    // read address
	input  wire logic        s_axi_arvalid,   // read address valid
	output logic             s_axi_arready,   // read address ready
	output logic [31:0]      s_axi_rdata,     // read data
	output logic [1:0]       s_axi_rresp,     // read response
	output logic             s_axi_rvalid,    // read data valid
	input  wire logic        s_axi_rready,    // read data ready
	input  wire logic        rx_stop_char,    // stop char received, pulse
	input  wire logic        rx_resume_char,  // resume char received, pulse
	input  wire logic        rx_addr_match,   // address char matched, pulse
	input  wire logic        tx_busy,         // character in progress
	input  wire logic        tx_char_done,    // character finished, pulse
	input  wire logic        bit_tick,        // bit-time enable pulse
	input  wire logic        tx_queue_empty,  // tx_queue empty
	input  wire logic        send_stop_cmd,   // stop char send command
	input  wire logic        send_resume_cmd, // resume char send command
	input  wire logic        tx_sent_stop,    // stop char sent, pulse
	input  wire logic        tx_sent_resume,  // resume char sent, pulse
	output logic             tx_halt,         // transmitter held off
	output logic             watchdog_en,     // receiver watchdog enable
	output logic             addr_recog_en,   // address recognition enable
	output logic             xon_recog_en,    // resume recognition enable
	output logic             xoff_recog_en    // stop recognition enable
);
	// bus state
	logic        aw_held, next_aw_held;
	logic        w_held, next_w_held;
	logic [7:0]  wr_addr, next_wr_addr;
	logic [31:0] wr_data, next_wr_data;
	logic [3:0]  wr_strb, next_wr_strb;
	logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        wr_fire, rd_fire;

	// block state
	logic        auto_rx_flow_enable, next_auto_rx;
	logic        auto_tx_flow_enable, next_auto_tx;
	logic [1:0]  rx_seen, next_rx_seen;
	logic [1:0]  tx_sent, next_tx_sent;
	logic [3:0]  int_status, next_int_status;
	logic [3:0]  int_events;
	logic        recog_wr;
	logic [7:0]  flow_status_val;

	// carrier to the flow tracker
	xfs_flow_if fl ();

	// decoded write to one register, low byte lane present
	function automatic logic wr_hit(input logic [7:0] a, input logic [3:0] s,
		input logic [7:0] ofs);
		wr_hit = (a == ofs) && s[0];
	endfunction

	assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
	assign rd_fire  = s_axi_arvalid && s_axi_arready;
	assign recog_wr = wr_fire && wr_hit(wr_addr, wr_strb, `XFS_OFS_RECOG_CTRL);

	// stop/resume drive the transmitter only in auto mode with recognition on
	assign fl.halt_req     = rx_stop_char && xoff_recog_en && auto_tx_flow_enable;
	assign fl.resume_req   = rx_resume_char && xon_recog_en && auto_tx_flow_enable;
	assign fl.tx_busy      = tx_busy;
	assign fl.tx_char_done = tx_char_done;
	assign fl.bit_tick     = bit_tick;
	assign fl.queue_empty  = tx_queue_empty;
	assign fl.send_stop    = send_stop_cmd;
	assign fl.send_resume  = send_resume_cmd;
	assign fl.sent_stop    = tx_sent_stop;
	assign fl.sent_resume  = tx_sent_resume;
	assign fl.status_read  = rd_fire && (s_axi_araddr == `XFS_OFS_FLOW_STATUS);

	xfs_tx_flow u_tx_flow (
		.clock (clock),
		.rst_b (rst_b),
		.fl    (fl.flow)
	);

	xfs_recog u_recog (
		.clock   (clock),
		.rst_b   (rst_b),
		.wr_stb  (recog_wr),
		.wr_data (wr_data[7:0]),
		.wdog_en (watchdog_en),
		.addr_en (addr_recog_en),
		.xon_en  (xon_recog_en),
		.xoff_en (xoff_recog_en)
	);

	// recognition events gated by their enables; general one by either flow enable with auto tx off
	assign int_events[`XFS_IS_XON]  = rx_resume_char && xon_recog_en;
	assign int_events[`XFS_IS_XOFF] = rx_stop_char && xoff_recog_en;
	assign int_events[`XFS_IS_ADDR] = rx_addr_match && addr_recog_en;
	assign int_events[`XFS_IS_GEN]  = (rx_resume_char || rx_stop_char) &&
		(xon_recog_en || xoff_recog_en) && !auto_tx_flow_enable;

	// flow_control_status as seen by a read
	always_comb begin
		flow_status_val = `XFS_BYTE_ZERO;
		flow_status_val[`XFS_RX_FIELD_HI:`XFS_RX_FIELD_LO]     = rx_seen;
		flow_status_val[`XFS_SENT_FIELD_HI:`XFS_SENT_FIELD_LO] = tx_sent;
		flow_status_val[`XFS_TXFLOW_HI:`XFS_TXFLOW_LO]         = fl.flow_code;
		flow_status_val[`XFS_TXCHAR_HI:`XFS_TXCHAR_LO]         = fl.char_code;
	end

	// status fields; a new event in the read cycle survives the clear
	always_comb begin
		next_rx_seen    = fl.status_read ? `XFS_CODE_NONE : rx_seen;
		next_tx_sent    = fl.status_read ? `XFS_CODE_NONE : tx_sent;
		next_int_status = int_status;
		next_auto_rx    = auto_rx_flow_enable;
		next_auto_tx    = auto_tx_flow_enable;

		// write one clears; events win
		if (wr_fire && wr_hit(wr_addr, wr_strb, `XFS_OFS_INT_STATUS))
			next_int_status = int_status & ~wr_data[3:0];
		if (wr_fire && wr_hit(wr_addr, wr_strb, `XFS_OFS_MODE_CTRL)) begin
			next_auto_rx = wr_data[`XFS_MC_AUTO_RX];
			next_auto_tx = wr_data[`XFS_MC_AUTO_TX];
		end
		next_int_status = next_int_status | int_events;

		// received field ignores enables
		if (rx_stop_char)
			next_rx_seen = next_rx_seen | `XFS_CODE_01;
		if (rx_resume_char)
			next_rx_seen = next_rx_seen | `XFS_CODE_10;
		if (tx_sent_resume && auto_rx_flow_enable)
			next_tx_sent = next_tx_sent | `XFS_CODE_01;
		if (tx_sent_stop && auto_rx_flow_enable)
			next_tx_sent = next_tx_sent | `XFS_CODE_10;
		// auto mode off: sent field wiped
		if (!next_auto_rx)
			next_tx_sent = `XFS_CODE_NONE;
	end

	// status and mode registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_seen             <= `XFS_CODE_NONE;
			tx_sent             <= `XFS_CODE_NONE;
			int_status          <= `XFS_NIB_ZERO;
			auto_rx_flow_enable <= 1'b0;
			auto_tx_flow_enable <= 1'b0;
		end else begin
			rx_seen             <= next_rx_seen;
			tx_sent             <= next_tx_sent;
			int_status          <= next_int_status;
			auto_rx_flow_enable <= next_auto_rx;
			auto_tx_flow_enable <= next_auto_tx;
		end
	end

	// write channel: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;

		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_wr_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held  = 1'b1;
			next_wr_data = s_axi_wdata;
			next_wr_strb = s_axi_wstrb;
		end
		// both halves held: do the write
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			unique case (wr_addr)
				`XFS_OFS_FLOW_STATUS, `XFS_OFS_RECOG_CTRL,
				`XFS_OFS_MODE_CTRL, `XFS_OFS_INT_STATUS: next_bresp = `XFS_RESP_OKAY;
				default: next_bresp = `XFS_RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;

		// ready drops while a word is held, so nothing is overwritten
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	// read channel: one outstanding read, answer one cycle after acceptance
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;

		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rdata  = `XFS_WORD_ZERO;
			next_rresp  = `XFS_RESP_OKAY;
			unique case (s_axi_araddr)
				`XFS_OFS_FLOW_STATUS: next_rdata[7:0] = flow_status_val;
				`XFS_OFS_RECOG_CTRL: begin
					next_rdata[`XFS_RE_WDOG_EN] = watchdog_en;
					next_rdata[`XFS_RE_ADDR_EN] = addr_recog_en;
					next_rdata[`XFS_RE_XON_EN]  = xon_recog_en;
					next_rdata[`XFS_RE_XOFF_EN] = xoff_recog_en;
				end
				`XFS_OFS_MODE_CTRL: begin
					next_rdata[`XFS_MC_AUTO_RX] = auto_rx_flow_enable;
					next_rdata[`XFS_MC_AUTO_TX] = auto_tx_flow_enable;
				end
				`XFS_OFS_INT_STATUS: next_rdata[3:0] = int_status;
				default: next_rresp = `XFS_RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		// one read outstanding at a time
		next_arready = !next_rvalid;
	end

	// bus registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// write side
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			wr_addr       <= `XFS_BYTE_ZERO;
			wr_data       <= `XFS_WORD_ZERO;
			wr_strb       <= `XFS_NIB_ZERO;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `XFS_RESP_OKAY;
			// read side
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `XFS_WORD_ZERO;
			s_axi_rresp   <= `XFS_RESP_OKAY;
		end else begin
			// write side
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			wr_addr       <= next_wr_addr;
			wr_data       <= next_wr_data;
			wr_strb       <= next_wr_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			// read side
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// halt output registered once more so it leaves a top-level flop
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			tx_halt <= 1'b0;
		else
			tx_halt <= fl.tx_halt;
	end
endmodule // xfs_top

// ==== verification/xfs_top_properties.sv ====
`timescale 1ns/1ps
// watches the top ports only
module xfs_top_properties (
	input wire logic        clock,          // clock
	input wire logic        rst_b,          // reset
	input wire logic [7:0]  s_axi_awaddr,   // aw addr
	input wire logic        s_axi_awvalid,  // aw valid
	input wire logic        s_axi_awready,  // aw ready
	input wire logic [31:0] s_axi_wdata,    // w data
	input wire logic        s_axi_wvalid,   // w valid
	input wire logic        s_axi_wready,   // w ready
	input wire logic        s_axi_bvalid,   // b valid
	input wire logic        s_axi_arvalid,  // ar valid
	input wire logic        s_axi_arready,  // ar ready
	input wire logic [31:0] s_axi_rdata,    // r data
	input wire logic        s_axi_rvalid,   // r valid
	input wire logic        s_axi_rready,   // r ready
	input wire logic        rx_resume_char, // resume in
	input wire logic        tx_busy,        // char busy
	input wire logic        tx_char_done,   // char done
	input wire logic        tx_halt,        // halted
	input wire logic        xon_recog_en,   // resume recog
	input wire logic        xoff_recog_en   // stop recog
);
	logic [7:0] wa;
	logic [7:0] wd;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// last write address and data, kept for the enable checks
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wa <= 8'h00;
			wd <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
		end
	end
	// write to the enable register lands when its answer rises
	sequence s_recog_wr;
		$rose(s_axi_bvalid) && wa == 8'h04;
	endsequence
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer not two edges after handshake");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_reset_quiet: assert property (
		$rose(rst_b) |-> !tx_halt && !xon_recog_en && !xoff_recog_en)
		else $error("outputs not idle after reset");
	a_halt_after_char: assert property (
		$rose(tx_halt) |-> !$past(tx_busy, 2) || $past(tx_char_done, 2))
		else $error("halt before character finished");
	a_resume_release: assert property (
		$fell(tx_halt) |-> $past(rx_resume_char, 2))
		else $error("halt released without resume");
	a_both_disable: assert property (
		s_recog_wr ##0 wd[1:0] == 2'h3 |-> ##[1:3] !xoff_recog_en)
		else $error("enable and disable together left enabled");
	a_zero_no_action: assert property (
		s_recog_wr ##0 wd[1:0] == 2'h0 |-> $stable(xoff_recog_en) [*3])
		else $error("zero write changed an enable");
	a_enable_set: assert property (
		s_recog_wr ##0 wd[1:0] == 2'h1 |-> ##[1:3] xoff_recog_en)
		else $error("enable write ignored");
endmodule // xfs_top_properties

bind xfs_top xfs_top_properties u_chk (.*);

// ==== verification/xfs_remote_uart.sv ====
`timescale 1ns/1ps
// far serial end: one character time on the line, then an arrival pulse
module xfs_remote_uart (
	input wire logic       clock,    // clock
	input wire logic       rst_b,    // reset
	input wire logic       req,      // send request
	input wire logic [1:0] code,     // 1 stop, 2 resume, 3 address
	output logic           busy,     // character on the line
	output logic           stop_p,   // stop char arrived
	output logic           resume_p, // resume char arrived
	output logic           addr_p    // address char arrived
);
	logic [5:0] cnt;
	logic [1:0] cur;
	// pulse lasts one cycle so the receiver sees each character once
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 6'h00;
			cur <= 2'h0;
			busy <= 1'h0;
			{stop_p, resume_p, addr_p} <= 3'h0;
		end else begin
			{stop_p, resume_p, addr_p} <= 3'h0;
			if (req && !busy) begin
				busy <= 1'h1;
				cnt <= 6'h27;
				cur <= code;
			end else if (busy && cnt == 6'h00) begin
				busy <= 1'h0;
				{stop_p, resume_p, addr_p} <= {cur == 2'h1, cur == 2'h2, cur == 2'h3};
			end else if (busy) begin
				cnt <= cnt - 6'h01;
			end
		end
	end
endmodule // xfs_remote_uart

// ==== verification/xfs_top_tb.sv ====
`timescale 1ns/1ps
module xfs_top_tb;
	logic        clock, rst_b, req, busy, bit_tick, tx_busy, tx_queue_empty;
	logic [1:0]  code, s_axi_bresp, s_axi_rresp, rs_q;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
	logic [3:0]  s_axi_wstrb;
	logic [4:0]  ev_v;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, rx_stop_char, rx_resume_char, rx_addr_match;
	logic        tx_char_done, send_stop_cmd, send_resume_cmd, tx_sent_stop, tx_sent_resume;
	logic        tx_halt, watchdog_en, addr_recog_en, xon_recog_en, xoff_recog_en;
	int          num_errors = 0;
	int          cmp_count = 0;
	// one-cycle transmit side events
	assign {tx_char_done, send_stop_cmd, send_resume_cmd, tx_sent_stop, tx_sent_resume} = ev_v;
	xfs_top u_dut (.*);
	xfs_remote_uart u_far (.clock(clock), .rst_b(rst_b), .req(req), .code(code), .busy(busy),
		.stop_p(rx_stop_char), .resume_p(rx_resume_char), .addr_p(rx_addr_match));
	always #4 clock = ~clock;
	task automatic close_out;
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkp(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	// bus tasks: ready sampled before the edge's own updates land
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 50);
		if (!s_axi_bvalid) num_errors++;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 50);
		if (!s_axi_rvalid) num_errors++;
		rd_q = s_axi_rdata;
		rs_q = s_axi_rresp;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(rd_q & m, e);
	endtask
	task automatic ev(input logic [4:0] s);
		@(posedge clock);
		ev_v <= s;
		@(posedge clock);
		ev_v <= 5'h00;
	endtask
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clock);
			bit_tick <= 1'h1;
			@(posedge clock);
			bit_tick <= 1'h0;
		end
	endtask
	// far end sends one character and we wait for its arrival
	task automatic remote(input logic [1:0] c);
		int n;
		n = 0;
		@(posedge clock);
		req <= 1'h1;
		code <= c;
		@(posedge clock);
		req <= 1'h0;
		repeat (2) @(posedge clock);
		while (busy && n < 100) begin
			@(posedge clock);
			n++;
		end
		if (busy) num_errors++;
		repeat (2) @(posedge clock);
	endtask
	// watchdog sized well above the several hundred cycles of the tests
	initial begin
		#200000;
		num_errors++;
		close_out;
	end
	initial begin
		clock = 0;
		rst_b = 0;
		{req, code, bit_tick, tx_busy, ev_v, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		tx_queue_empty = 1;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1;
		s_axi_rready = 1;
		repeat (3) @(posedge clock);
		rst_b <= 1'h1;
		@(posedge clock);
		rdc(8'h00, 32'hFF, 32'h00);
		remote(2'h1);
		remote(2'h2);
		rdc(8'h00, 32'hC0, 32'hC0);
		rdc(8'h00, 32'hF0, 32'h00);
		wr(8'h10, 32'hFF, 2'h2);
		rd(8'h10);
		chk({rs_q, rd_q[29:0]}, 32'h8000_0000);
		wr(8'h04, 32'h55, 2'h0);
		rdc(8'h04, 32'hFF, 32'h55);
		chkp(watchdog_en & addr_recog_en & xon_recog_en & xoff_recog_en, 1'h1);
		wr(8'h04, 32'h00, 2'h0);
		rdc(8'h04, 32'hFF, 32'h55);
		wr(8'h04, 32'hC3, 2'h0);
		rdc(8'h04, 32'hFF, 32'h14);
		wr(8'h04, 32'h41, 2'h0);
		remote(2'h1);
		rdc(8'h0C, 32'h08, 32'h08);
		chkp(tx_halt, 1'h0);
		remote(2'h3);
		rdc(8'h0C, 32'h04, 32'h04);
		wr(8'h0C, 32'h0F, 2'h0);
		rdc(8'h0C, 32'h0F, 32'h00);
		wr(8'h08, 32'h03, 2'h0);
		ev(5'h02);
		rdc(8'h00, 32'h30, 32'h20);
		ev(5'h02);
		ev(5'h01);
		rdc(8'h00, 32'h30, 32'h30);
		ev(5'h02);
		wr(8'h08, 32'h02, 2'h0);
		rdc(8'h00, 32'h30, 32'h00);
		ev(5'h02);
		rdc(8'h00, 32'h30, 32'h00);
		ev(5'h04);
		rdc(8'h00, 32'h03, 32'h03);
		ev(5'h01);
		rdc(8'h00, 32'h03, 32'h01);
		tick(1);
		rdc(8'h00, 32'h03, 32'h01);
		tx_queue_empty <= 1'h0;
		tick(1);
		rdc(8'h00, 32'h03, 32'h00);
		ev(5'h08);
		rdc(8'h00, 32'h03, 32'h02);
		tick(10);
		rdc(8'h00, 32'h03, 32'h01);
		wr(8'h08, 32'h03, 2'h0);
		tx_busy <= 1'h1;
		remote(2'h1);
		rdc(8'h00, 32'h0C, 32'h04);
		tx_busy <= 1'h0;
		ev(5'h10);
		rdc(8'h00, 32'h0C, 32'h0C);
		chkp(tx_halt, 1'h1);
		remote(2'h2);
		rdc(8'h00, 32'h0C, 32'h08);
		rdc(8'h00, 32'h0C, 32'h00);
		chkp(tx_halt, 1'h0);
		close_out;
	end
endmodule // xfs_top_tb
